//--- hdl/astx_pkg.sv
// package: constants and carriers for the async serial transmitter
package astx_pkg;
   localparam int BAUD_W = 13;
   localparam logic [3:0] FRAME_LEN_8 = 4'ha;
   localparam logic [3:0] FRAME_LEN_9 = 4'hb;
   localparam logic [3:0] BREAK_LEN_10 = 4'ha;
   localparam logic [3:0] BREAK_LEN_11 = 4'hb;
   localparam logic [3:0] BREAK_LEN_13 = 4'hd;
   localparam logic [3:0] BREAK_LEN_14 = 4'he;
   localparam logic [13:0] SHIFT_IDLE = 14'h3fff;
   localparam logic [13:0] SHIFT_BREAK = 14'h0000;
   localparam logic [8:0] BUF_RESET = 9'h000;
   localparam logic TX_LINE_RESET = 1'b1;
   localparam logic BUF_EMPTY_RESET = 1'b1;
   localparam logic TX_DONE_RESET = 1'b1;

   typedef struct packed {
      logic senderActive;
      logic outputPolarityFlip;
      logic nineBitSel;
      logic longBreakSelect;
      logic breakRequest;
   } astx_ctrl_s;

   typedef struct packed {
      logic txBufferEmptyFlag;
      logic txCompleteFlag;
   } astx_stat_s;
endpackage

//--- hdl/astx_transmitter.sv
// async serial transmitter with pin hand-back and receive bit-boundary resync
`timescale 1ns/1ps
module astx_transmitter #(
   parameter int BAUD_W = astx_pkg::BAUD_W
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control and baud divisor
   input wire astx_pkg::astx_ctrl_s ctrl,
   input wire logic [BAUD_W-1:0] baudDiv,
   // transmit buffer write
   input wire logic shiftDataWr,
   input wire logic [8:0] shiftDataPort,
   // serial pin
   output logic txLine,
   output logic txLineOe,
   // receive line and its bit boundary
   input wire logic rxLine,
   output logic rxBitBoundary,
   // status
   output astx_pkg::astx_stat_s stat
);
   function automatic logic [3:0] breakLen(input logic longBrk, input logic nine);
      logic [3:0] r;
      r = astx_pkg::BREAK_LEN_10;
      unique case ({longBrk, nine})
         2'b00: r = astx_pkg::BREAK_LEN_10;
         2'b01: r = astx_pkg::BREAK_LEN_11;
         2'b10: r = astx_pkg::BREAK_LEN_13;
         2'b11: r = astx_pkg::BREAK_LEN_14;
      endcase
      return r;
   endfunction

   function automatic logic [13:0] dataFrame(input logic [8:0] d, input logic nine);
      logic [13:0] r;
      r = nine ? {3'h7, 1'b1, d, 1'b0} : {4'hf, 1'b1, d[7:0], 1'b0};
      return r;
   endfunction

   logic [BAUD_W-1:0] baudCnt_q, baudCnt_d;
   logic [BAUD_W-1:0] rxCnt_q, rxCnt_d;
   logic [13:0] shift_q, shift_d;
   logic [3:0] bitsLeft_q, bitsLeft_d;
   logic [8:0] buf_q;
   logic bufFull_q, bufFull_d;
   logic idleQ_q, idleQ_d;
   logic breakQ_q, breakQ_d;
   logic teQ_q, brkReqQ_q, rxPrev_q;
   logic txDone_d;

   wire tick = (baudCnt_q == '0);
   wire shiftFree = tick && (bitsLeft_q <= 4'h1);
   wire teRise = ctrl.senderActive && !teQ_q;
   wire brkRise = ctrl.breakRequest && !brkReqQ_q;
   // queued idle first, then break, then data
   wire loadIdle = shiftFree && idleQ_q;
   wire loadBreak = shiftFree && !idleQ_q && breakQ_q;
   wire loadData = shiftFree && !idleQ_q && !breakQ_q && bufFull_q && ctrl.senderActive;
   wire loadAny = loadIdle || loadBreak || loadData;
   wire frameEnd = shiftFree && (bitsLeft_q == 4'h1) && !loadAny;
   wire [3:0] frameLen = ctrl.nineBitSel ? astx_pkg::FRAME_LEN_9 : astx_pkg::FRAME_LEN_8;
   wire rxFall = rxPrev_q && !rxLine;

   assign baudCnt_d = tick ? baudDiv : baudCnt_q - 1'b1;
   assign rxCnt_d = (rxFall || rxCnt_q == '0) ? baudDiv : rxCnt_q - 1'b1;

   always_comb begin
      shift_d = shift_q;
      bitsLeft_d = bitsLeft_q;
      if (loadIdle) begin
         shift_d = astx_pkg::SHIFT_IDLE;
         bitsLeft_d = frameLen;
      end else if (loadBreak) begin
         shift_d = astx_pkg::SHIFT_BREAK;
         bitsLeft_d = breakLen(ctrl.longBreakSelect, ctrl.nineBitSel);
      end else if (loadData) begin
         shift_d = dataFrame(buf_q, ctrl.nineBitSel);
         bitsLeft_d = frameLen;
      end else if (tick && bitsLeft_q != 4'h0) begin
         shift_d = {1'b1, shift_q[13:1]};
         bitsLeft_d = bitsLeft_q - 4'h1;
      end
   end

   assign bufFull_d = shiftDataWr || (bufFull_q && !loadData);
   assign idleQ_d = teRise || (idleQ_q && !loadIdle);
   assign breakQ_d = brkRise || (loadBreak && ctrl.breakRequest) || (breakQ_q && !loadBreak);
   assign txDone_d = frameEnd || (stat.txCompleteFlag && !loadAny);
   wire lineBit = (bitsLeft_d == 4'h0) ? 1'b1 : shift_d[0];
   wire oe_d = ctrl.senderActive || (bitsLeft_d != 4'h0) || idleQ_d || breakQ_d;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         baudCnt_q <= '0;
         rxCnt_q <= '0;
         shift_q <= astx_pkg::SHIFT_IDLE;
         bitsLeft_q <= 4'h0;
         buf_q <= astx_pkg::BUF_RESET;
         bufFull_q <= 1'b0;
         idleQ_q <= 1'b0;
         breakQ_q <= 1'b0;
         teQ_q <= 1'b0;
         brkReqQ_q <= 1'b0;
         rxPrev_q <= 1'b1;
         txLine <= astx_pkg::TX_LINE_RESET;
         txLineOe <= 1'b0;
         rxBitBoundary <= 1'b0;
         stat.txBufferEmptyFlag <= astx_pkg::BUF_EMPTY_RESET;
         stat.txCompleteFlag <= astx_pkg::TX_DONE_RESET;
      end else begin
         baudCnt_q <= baudCnt_d;
         rxCnt_q <= rxCnt_d;
         shift_q <= shift_d;
         bitsLeft_q <= bitsLeft_d;
         if (shiftDataWr) begin
            buf_q <= shiftDataPort;
         end
         bufFull_q <= bufFull_d;
         idleQ_q <= idleQ_d;
         breakQ_q <= breakQ_d;
         teQ_q <= ctrl.senderActive;
         brkReqQ_q <= ctrl.breakRequest;
         rxPrev_q <= rxLine;
         txLine <= lineBit ^ ctrl.outputPolarityFlip;
         txLineOe <= oe_d;
         rxBitBoundary <= (rxCnt_q == '0) && !rxFall;
         stat.txBufferEmptyFlag <= !bufFull_d;
         stat.txCompleteFlag <= txDone_d;
      end
   end

   // checks
   sequence s_dataLoad;
      loadData && !shiftDataWr;
   endsequence

   property p_polarity;
      @(posedge clk) disable iff (!rst_n)
         $past(rst_n) |-> (txLine ^ $past(ctrl.outputPolarityFlip)) ==
            ((bitsLeft_q == 4'h0) || shift_q[0]);
   endproperty
   a_polarity: assert property (p_polarity) else $error("line level wrong");

   property p_preamble;
      @(posedge clk) disable iff (!rst_n)
         $rose(ctrl.senderActive) |=> idleQ_q;
   endproperty
   a_preamble: assert property (p_preamble) else $error("no preamble queued");

   property p_noEmptyLoad;
      @(posedge clk) disable iff (!rst_n)
         stat.txBufferEmptyFlag && !idleQ_q && !breakQ_q && !$past(shiftDataWr)
            |=> bitsLeft_q <= $past(bitsLeft_q);
   endproperty
   a_noEmptyLoad: assert property (p_noEmptyLoad) else $error("frame without data");

   property p_frameLen;
      @(posedge clk) disable iff (!rst_n)
         loadData |=> bitsLeft_q == ($past(ctrl.nineBitSel) ? 4'hb : 4'ha);
   endproperty
   a_frameLen: assert property (p_frameLen) else $error("frame length wrong");

   property p_frame8;
      @(posedge clk) disable iff (!rst_n)
         loadData && !ctrl.nineBitSel |=> !shift_q[0] && shift_q[9] &&
            shift_q[8:1] == $past(buf_q[7:0]);
   endproperty
   a_frame8: assert property (p_frame8) else $error("8-bit frame layout");

   property p_emptySet;
      @(posedge clk) disable iff (!rst_n)
         s_dataLoad |=> stat.txBufferEmptyFlag ##1 $stable(bitsLeft_q) || tick;
   endproperty
   a_emptySet: assert property (p_emptySet) else $error("empty flag not set");

   property p_complete;
      @(posedge clk) disable iff (!rst_n)
         frameEnd |=> stat.txCompleteFlag && bitsLeft_q == 4'h0 ##1
            (txLine == !$past(ctrl.outputPolarityFlip));
   endproperty
   a_complete: assert property (p_complete) else $error("complete not flagged");

   property p_hold;
      @(posedge clk) disable iff (!rst_n)
         $past(rst_n) && (bitsLeft_q != 4'h0 || idleQ_q || breakQ_q) |-> txLineOe;
   endproperty
   a_hold: assert property (p_hold) else $error("pin released early");

   property p_resync;
      @(posedge clk) disable iff (!rst_n)
         rxFall |=> rxCnt_q == $past(baudDiv) && !rxBitBoundary;
   endproperty
   a_resync: assert property (p_resync) else $error("no resync on fall");

   property p_breakLen;
      @(posedge clk) disable iff (!rst_n)
         loadBreak |=> shift_q == 14'h0000 && bitsLeft_q ==
            breakLen($past(ctrl.longBreakSelect), $past(ctrl.nineBitSel));
   endproperty
   a_breakLen: assert property (p_breakLen) else $error("break length wrong");

   property p_rebreak;
      @(posedge clk) disable iff (!rst_n)
         loadBreak && ctrl.breakRequest |=> breakQ_q;
   endproperty
   a_rebreak: assert property (p_rebreak) else $error("break not requeued");

   property p_wrClears;
      @(posedge clk) disable iff (!rst_n)
         shiftDataWr |=> !stat.txBufferEmptyFlag;
   endproperty
   a_wrClears: assert property (p_wrClears) else $error("write left empty set");

   property p_startClears;
      @(posedge clk) disable iff (!rst_n)
         loadAny |=> !stat.txCompleteFlag;
   endproperty
   a_startClears: assert property (p_startClears) else $error("complete not cleared");
endmodule

//--- tb/astx_remote_rx.sv
// remote receiver model sampling the line mid-bit
`timescale 1ns/1ps
module astx_remote_rx #(
   parameter int BIT_CLKS = 4
) (
   // clock and line
   input wire logic clk,
   input wire logic line,
   input wire logic inv,
   // received character
   output logic [7:0] rxByte,
   output logic rxStop,
   output int rxCount
);
   initial begin
      rxCount = 0;
      rxByte = 8'h00;
      rxStop = 1'b0;
   end
   always begin
      @(posedge clk);
      if ((line ^ inv) === 1'b0) begin
         repeat (BIT_CLKS / 2 - 1) @(posedge clk);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge clk);
            rxByte[i] = line ^ inv;
         end
         repeat (BIT_CLKS) @(posedge clk);
         rxStop = line ^ inv;
         rxCount++;
         while ((line ^ inv) === 1'b0) @(posedge clk);
      end
   end
endmodule

//--- tb/astx_transmitter_bench.sv
// bench for the async serial transmitter
`timescale 1ns/1ps
module astx_transmitter_bench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   astx_pkg::astx_ctrl_s ctrl = '0;
   logic [12:0] baudDiv = 13'h0003;
   logic shiftDataWr = 1'b0;
   logic [8:0] shiftDataPort = 9'h000;
   logic txLine, txLineOe, rxStop;
   logic invRx = 1'b0;
   logic rxLine = 1'b1;
   logic rxBitBoundary;
   // released pin pulled to the idle level
   wire pinLine = txLineOe ? txLine : !invRx;
   logic [7:0] rxByte;
   astx_pkg::astx_stat_s stat;
   int rxCount, n, lowCnt;
   int numErrors = 0;
   int checksDone = 0;
   int brk [5][4] = '{'{0, 0, 1, 10}, '{0, 1, 1, 11}, '{1, 0, 1, 13}, '{1, 1, 1, 14},
      '{0, 0, 8, 20}};
   always #2 clk = ~clk;
   astx_transmitter astx_transmitter_i (.clk(clk), .rst_n(rst_n), .ctrl(ctrl),
      .baudDiv(baudDiv), .shiftDataWr(shiftDataWr), .shiftDataPort(shiftDataPort),
      .txLine(txLine), .txLineOe(txLineOe), .rxLine(rxLine), .rxBitBoundary(rxBitBoundary),
      .stat(stat));
   astx_remote_rx #(.BIT_CLKS(4)) astx_remote_rx_i (.clk(clk), .line(pinLine), .inv(invRx),
      .rxByte(rxByte), .rxStop(rxStop), .rxCount(rxCount));
   task automatic stopTest();
      $display("checks %0d errors %0d", checksDone, numErrors);
      if (numErrors == 0 && checksDone > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
      checksDone++;
      if (seen !== exp) begin
         numErrors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic waitCond(input int which, output int cnt);
      int start;
      logic hit;
      start = rxCount;
      cnt = 0;
      hit = 1'b0;
      while (!hit) begin
         @(negedge clk);
         cnt++;
         case (which)
            0: hit = stat.txBufferEmptyFlag === 1'b1;
            1: hit = stat.txCompleteFlag === 1'b1;
            2: hit = txLineOe === 1'b0;
            3: hit = txLine === 1'b0;
            default: hit = rxCount == start + 1;
         endcase
         if (cnt > 2000) begin
            check("wait", 9'(which), 9'h1ff);
            stopTest();
         end
      end
   endtask
   task automatic sendByte(input logic [8:0] d);
      @(negedge clk);
      shiftDataWr = 1'b1;
      shiftDataPort = d;
      @(negedge clk);
      shiftDataWr = 1'b0;
      check("empty", stat.txBufferEmptyFlag, 1'b0);
   endtask
   task automatic recv(input logic [7:0] d);
      waitCond(4, n);
      check("byte", rxByte, d);
      check("stop", rxStop, 1'b1);
   endtask
   // falling receive line: boundary only five clocks later
   task automatic rxFallTest();
      rxLine = 1'b0;
      for (int c = 1; c <= 5; c++) begin
         @(negedge clk);
         check("boundary", 9'(rxBitBoundary), 9'(c == 5));
      end
      rxLine = 1'b1;
   endtask
   initial begin
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      check("line", txLine, 1'b1);
      check("oe", txLineOe, 1'b0);
      check("flags", stat, 2'b11);
      ctrl.senderActive = 1'b1;
      lowCnt = 0;
      repeat (100) begin
         @(negedge clk);
         if (txLine !== 1'b1) lowCnt++;
      end
      check("idle", 9'(lowCnt), 9'h000);
      sendByte(8'ha5);
      recv(8'ha5);
      sendByte(8'h3c);
      waitCond(0, n);
      sendByte(8'hc3);
      recv(8'h3c);
      recv(8'hc3);
      waitCond(1, n);
      check("done line", txLine, 1'b1);
      ctrl.outputPolarityFlip = 1'b1;
      @(negedge clk);
      invRx = 1'b1;
      @(negedge clk);
      check("inv idle", txLine, 1'b0);
      sendByte(8'h5a);
      recv(8'h5a);
      ctrl.outputPolarityFlip = 1'b0;
      @(negedge clk);
      invRx = 1'b0;
      for (int k = 0; k < 5; k++) begin
         ctrl.longBreakSelect = brk[k][0][0];
         ctrl.nineBitSel = brk[k][1][0];
         ctrl.breakRequest = 1'b1;
         lowCnt = 0;
         for (int c = 0; c < 120; c++) begin
            @(negedge clk);
            if (c == brk[k][2]) ctrl.breakRequest = 1'b0;
            if (txLine === 1'b0) lowCnt++;
         end
         check("break", 9'(lowCnt), 9'(brk[k][3] * 4));
      end
      ctrl.nineBitSel = 1'b0;
      ctrl.longBreakSelect = 1'b0;
      sendByte(8'h96);
      waitCond(3, n);
      check("complete", stat.txCompleteFlag, 1'b0);
      ctrl.senderActive = 1'b0;
      @(negedge clk);
      check("oe held", txLineOe, 1'b1);
      recv(8'h96);
      waitCond(2, n);
      ctrl.senderActive = 1'b1;
      sendByte(8'h69);
      waitCond(3, n);
      check("preamble", 9'(n >= 30), 9'h001);
      recv(8'h69);
      rxFallTest();
      @(negedge clk);
      rxFallTest();
      ctrl.nineBitSel = 1'b1;
      sendByte(9'h0a5);
      waitCond(3, n);
      waitCond(1, n);
      check("nine len", 9'(n), 9'h02c);
      check("nine data", rxByte, 8'ha5);
      check("nine bit", rxStop, 1'b0);
      stopTest();
   end
endmodule
